/* File: dv/can_msg_buffer_tx_priority_tb.sv */
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("CHECK FAILED %0t got %h expected %h", $time, a, b); end end
module can_msg_buffer_tx_priority_tb import cmb_pkg::*; ();
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_in = 1'b0, reset_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, tx_done_in, tx_start_out, tx_remote_out;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
   logic tx_format_out;
   logic [1:0] tx_index_out;
   logic [10:0] tx_tag_out;
   logic [3:0] tx_len_code_out, tx_byte_cnt_out, dly = 4'h3;
   logic [63:0] tx_payload_out;
   logic [2:0] free_out;
   int num_errors = 0, comparisons = 0;
   initial forever #2.5 ref_clk_in = ~ref_clk_in;
   cmb_tx_buf #(.NB(3)) dut (.ref_clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .tx_done_in,
      .tx_start_out, .tx_index_out, .tx_tag_out, .tx_remote_out, .tx_format_out, .tx_len_code_out, .tx_byte_cnt_out,
      .tx_payload_out, .free_out);
   cmb_can_node node (.ref_clk_in, .tx_start_in(tx_start_out), .dly_in(dly), .tx_done_out(tx_done_in));
   task automatic final_report;
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_in);
      {rd_in, addr_in} <= {1'b1, a};
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 `CHK(rdata_out, e)
   endtask : rd
   task automatic load(input logic [1:0] b, input logic [7:0] up, lo, len, rank);
      wr(OFS_SELECT, {6'h00, b});
      wr(OFS_ARB_UPPER, up);
      wr(OFS_ARB_LOWER, lo);
      for (int k = 0; k < 8; k++) wr(OFS_PAYLOAD0 + 8'(k), {4'(b) + 4'h1, 4'(k)});
      wr(OFS_LENGTH, len);
      wr(OFS_RANK, rank);
      wr(OFS_ARB_X2, 8'hff);
      rd(OFS_RANK, rank);
      rd(OFS_ARB_LOWER, lo);
      rd(OFS_PAYLOAD0 + 8'h05, {4'(b) + 4'h1, 4'h5});
      rd(OFS_ARB_X2, UNUSED_READ);
   endtask : load
   task automatic bail;
      num_errors++;
      final_report();
   endtask : bail
   task automatic expect_tx(input logic [1:0] b, input logic [7:0] up, lo, input logic [3:0] len, cnt);
      int n;
      logic [63:0] p;
      wr(OFS_ARB_REQ, 8'h01);
      #1;
      for (n = 0; n < 20 && tx_start_out !== 1'b1; n++) @(posedge ref_clk_in) #1;
      if (n == 20) bail();
      for (int k = 0; k < 8; k++) p[k*8 +: 8] = {4'(b) + 4'h1, 4'(k)};
      `CHK(tx_index_out, b)
      `CHK(tx_tag_out, {up, lo[TAG_LO_MSB:TAG_LO_LSB]})
      `CHK({tx_remote_out, tx_format_out}, {lo[RTR_BIT], lo[FMT_BIT]})
      `CHK({tx_len_code_out, tx_byte_cnt_out}, {len, cnt})
      `CHK(tx_payload_out, p)
      rd(OFS_WINNER, {1'b1, 5'h00, b});
      for (n = 0; n < 20 && free_out[b] !== 1'b1; n++) @(posedge ref_clk_in) #1;
      if (n == 20) bail();
   endtask : expect_tx
   initial begin
      repeat (8) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      load(2'h0, 8'h81, 8'he8, 8'h0f, 8'h05);
      load(2'h1, 8'h12, 8'h20, 8'h03, 8'h02);
      load(2'h2, 8'h12, 8'hb0, 8'h05, 8'h02);
      wr(OFS_FREE_FLAGS, 8'h07);
      rd(OFS_FREE_FLAGS, 8'h00);
      wr(OFS_RANK, 8'h01);
      rd(OFS_RANK, 8'h00);
      expect_tx(2'h1, 8'h12, 8'h20, 4'h3, 4'h3);
      expect_tx(2'h2, 8'h12, 8'hb0, 4'h5, 4'h0);
      expect_tx(2'h0, 8'h81, 8'he8, 4'hf, 4'h8);
      rd(OFS_FREE_FLAGS, 8'h07);
      final_report();
   end
endmodule : can_msg_buffer_tx_priority_tb
`default_nettype wire

/* File: dv/cmb_can_node.sv */
`default_nettype none
module cmb_can_node (
   input wire logic ref_clk_in,
   input wire logic tx_start_in,
   input wire logic [3:0] dly_in,
   output logic tx_done_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      tx_done_out = 1'b0;
      forever begin
         @(posedge ref_clk_in);
         if (tx_start_in) begin
            repeat (dly_in) @(posedge ref_clk_in);
            tx_done_out <= 1'b1; // Frame acknowledged
            @(posedge ref_clk_in);
            tx_done_out <= 1'b0;
         end
      end
   end
endmodule : cmb_can_node
`default_nettype wire

/* File: dv/cmb_tx_asserts.sv */
`default_nettype none
module cmb_tx_asserts
   import cmb_pkg::*;
#(parameter int NB = 3) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [REG_AW-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic tx_done_in,
   input wire logic tx_start_out,
   input wire logic [1:0] tx_index_out,
   input wire logic [10:0] tx_tag_out,
   input wire logic tx_remote_out,
   input wire logic [3:0] tx_len_code_out,
   input wire logic [3:0] tx_byte_cnt_out,
   input wire logic [NB-1:0] free_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_req; wr_in && addr_in == OFS_ARB_REQ && wdata_in[0]; endsequence
   sequence s_freed; ##2 free_out[$past(tx_index_out, 2)]; endsequence
   a_start_cause: assert property (tx_start_out |-> $past(wr_in && addr_in == OFS_ARB_REQ && wdata_in[0]))
      else $error("start without request");
   a_start_pulse: assert property (s_req ##1 tx_start_out |=> !tx_start_out) else $error("start too long");
   a_winner_busy: assert property (tx_start_out |-> !free_out[tx_index_out]) else $error("free buffer sent");
   a_remote_empty: assert property (tx_start_out && tx_remote_out |-> tx_byte_cnt_out == 4'h0) else $error("remote");
   a_count_clamp: assert property (tx_start_out && !tx_remote_out |->
      tx_byte_cnt_out == (tx_len_code_out > MAX_BYTES ? MAX_BYTES : tx_len_code_out)) else $error("count");
   a_frame_hold: assert property (!tx_start_out |-> $stable({tx_tag_out, tx_len_code_out})) else $error("frame");
   a_unused_zero: assert property (rd_in && addr_in == OFS_ARB_X2 |=> rdata_out == UNUSED_READ) else $error("x2");
   a_done_frees: assert property (tx_done_in |-> s_freed) else $error("done did not free");
endmodule : cmb_tx_asserts
bind cmb_tx_buf cmb_tx_asserts #(.NB(NB)) u_chk (.ref_clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .rdata_out, .tx_done_in, .tx_start_out, .tx_index_out, .tx_tag_out, .tx_remote_out, .tx_len_code_out,
   .tx_byte_cnt_out, .free_out);
`default_nettype wire

/* File: hw/cmb_pkg.sv */
`default_nettype none
package cmb_pkg;
   localparam int NUM_TX_BUF = 3;
   localparam int PAYLOAD_BYTES = 8;
   localparam int REG_AW = 8;
   // Per-buffer register offsets inside the transmit window
   localparam logic [7:0] OFS_ARB_UPPER = 8'h00;
   localparam logic [7:0] OFS_ARB_LOWER = 8'h01;
   localparam logic [7:0] OFS_ARB_X2 = 8'h02;
   localparam logic [7:0] OFS_ARB_X3 = 8'h03;
   localparam logic [7:0] OFS_PAYLOAD0 = 8'h04;
   localparam logic [7:0] OFS_LENGTH = 8'h0c;
   localparam logic [7:0] OFS_RANK = 8'h0d;
   // Control and status registers
   localparam logic [7:0] OFS_FREE_FLAGS = 8'h10;
   localparam logic [7:0] OFS_SELECT = 8'h11;
   localparam logic [7:0] OFS_ARB_REQ = 8'h12;
   localparam logic [7:0] OFS_WINNER = 8'h13;
   localparam logic [7:0] OFS_TX_DONE = 8'h14;
   // Field positions
   localparam int RTR_BIT = 4;
   localparam int FMT_BIT = 3;
   localparam int TAG_LO_MSB = 7;
   localparam int TAG_LO_LSB = 5;
   localparam int LEN_MSB = 3;
   localparam logic [3:0] MAX_BYTES = 4'h8;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] UNUSED_READ = 8'h00;
   localparam logic [1:0] WIN_NONE = 2'h3;
endpackage : cmb_pkg
`default_nettype wire

/* File: hw/cmb_prio_sel.sv */
`default_nettype none
module cmb_prio_sel #(
   parameter int NB = 3
) (
   cmb_sel_if.chooser sel
);
   // Scan lowest index first; strict less-than keeps the lower index on ties
   always_comb begin
      logic [7:0] best;
      best = 8'h00;
      sel.valid = 1'b0;
      sel.index = 2'h0;
      for (int i = 0; i < NB; i++) begin
         if (sel.req[i] && (!sel.valid || sel.ranks[i*8 +: 8] < best)) begin
            sel.valid = 1'b1;
            sel.index = i[1:0];
            best = sel.ranks[i*8 +: 8];
         end
      end
   end
endmodule : cmb_prio_sel
`default_nettype wire

/* File: hw/cmb_sel_if.sv */
`default_nettype none
interface cmb_sel_if #(parameter int NB = 3);
   logic [NB-1:0] req;
   logic [NB*8-1:0] ranks;
   logic valid;
   logic [1:0] index;
   modport chooser (input req, input ranks, output valid, output index);
   modport user (output req, output ranks, input valid, input index);
endinterface : cmb_sel_if
`default_nettype wire

/* File: hw/cmb_tx_buf.sv */
// Function
// - Eleven-bit tag split across both arbitration bytes
// - Smaller tag value wins bus arbitration
// - Bit 4 selects remote or data frame
// - Bit 3 selects standard or extended tag
// - Eight payload bytes per transmit buffer
// - Length code gives byte count 0..8
// - Remote frame sends code, zero payload bytes
// - Rank register holds local buffer priority
// - Ready buffers join selection before frame start
// - Lowest rank value wins the selection
// - Rank tie goes to lower buffer index
//
// Chosen here: the address map and the address-and-strobe port.
`default_nettype none
module cmb_tx_buf
   import cmb_pkg::*;
#(
   parameter int NB = 3
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [REG_AW-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic tx_done_in,
   output logic tx_start_out,
   output logic [1:0] tx_index_out,
   output logic [10:0] tx_tag_out,
   output logic tx_remote_out,
   output logic tx_format_out,
   output logic [3:0] tx_len_code_out,
   output logic [3:0] tx_byte_cnt_out,
   output logic [63:0] tx_payload_out,
   output logic [NB-1:0] free_out
);
   if (NB < 1 || NB > 3) begin : g_nb_check
      $error("cmb_tx_buf: NB must be 1..3");
   end
   logic [7:0] upper_r [NB];
   logic [7:0] lower_r [NB];
   logic [7:0] len_r [NB];
   logic [7:0] rank_r [NB];
   logic [7:0] pay_r [NB][PAYLOAD_BYTES];
   logic [NB-1:0] free_r;
   logic [1:0] sel_r;
   logic busy_r;
   logic start_req;
   logic sel_ok;
   cmb_sel_if #(.NB(NB)) sel_bus ();
   cmb_prio_sel #(.NB(NB)) u_sel (.sel(sel_bus));
   function automatic logic [3:0] byte_count(input logic [7:0] len, input logic remote_request_flag);
      if (remote_request_flag) byte_count = 4'h0;
      else if (len[LEN_MSB:0] > MAX_BYTES) byte_count = MAX_BYTES;
      else byte_count = len[LEN_MSB:0];
   endfunction : byte_count
   // Payload byte k sits at window offset OFS_PAYLOAD0 + k
   function automatic logic [2:0] pay_slot(input logic [REG_AW-1:0] addr);
      pay_slot = 3'(addr - OFS_PAYLOAD0);
   endfunction : pay_slot
   assign sel_ok = (int'(sel_r) < NB) && free_r[sel_r];
   assign start_req = wr_in && addr_in == OFS_ARB_REQ && wdata_in[0];
   always_comb begin
      for (int i = 0; i < NB; i++) begin
         sel_bus.req[i] = !free_r[i];
         sel_bus.ranks[i*8 +: 8] = rank_r[i];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Buffer registers written through the selected window
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < NB; i++) begin
            upper_r[i] <= RESET_BYTE;
            lower_r[i] <= RESET_BYTE;
            len_r[i] <= RESET_BYTE;
            rank_r[i] <= RESET_BYTE;
            for (int j = 0; j < PAYLOAD_BYTES; j++) pay_r[i][j] <= RESET_BYTE;
         end
      end else if (wr_in && sel_ok) begin
         if (addr_in == OFS_ARB_UPPER) upper_r[sel_r] <= wdata_in;
         if (addr_in == OFS_ARB_LOWER) lower_r[sel_r] <= wdata_in;
         if (addr_in == OFS_LENGTH) len_r[sel_r] <= wdata_in;
         if (addr_in == OFS_RANK) rank_r[sel_r] <= wdata_in;
         if (addr_in >= OFS_PAYLOAD0 && addr_in < OFS_LENGTH) pay_r[sel_r][pay_slot(addr_in)] <= wdata_in;
      end
   end
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) sel_r <= 2'h0;
      else if (wr_in && addr_in == OFS_SELECT) sel_r <= wdata_in[1:0];
   end
   ////////////////////////////////////////////////////////////////////////
   // Free flags: writing 1 marks ready; completion sets free and wins
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) free_r <= {NB{1'b1}};
      else begin
         for (int i = 0; i < NB; i++) begin
            if (busy_r && tx_done_in && tx_index_out == i[1:0]) free_r[i] <= 1'b1;
            else if (wr_in && addr_in == OFS_FREE_FLAGS && wdata_in[i]) free_r[i] <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Selection taken just before start of frame
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         busy_r <= 1'b0;
         tx_start_out <= 1'b0;
         tx_index_out <= WIN_NONE;
         tx_tag_out <= 11'h000;
         tx_remote_out <= 1'b0;
         tx_format_out <= 1'b0;
         tx_len_code_out <= 4'h0;
         tx_byte_cnt_out <= 4'h0;
         tx_payload_out <= 64'h0000_0000_0000_0000;
      end else begin
         tx_start_out <= 1'b0;
         if (busy_r && tx_done_in) busy_r <= 1'b0;
         else if (!busy_r && start_req && sel_bus.valid) begin
            busy_r <= 1'b1;
            tx_start_out <= 1'b1;
            tx_index_out <= sel_bus.index;
            tx_tag_out <= {upper_r[sel_bus.index], lower_r[sel_bus.index][TAG_LO_MSB:TAG_LO_LSB]};
            tx_remote_out <= lower_r[sel_bus.index][RTR_BIT];
            tx_format_out <= lower_r[sel_bus.index][FMT_BIT];
            tx_len_code_out <= len_r[sel_bus.index][LEN_MSB:0];
            tx_byte_cnt_out <= byte_count(len_r[sel_bus.index], lower_r[sel_bus.index][RTR_BIT]);
            for (int j = 0; j < PAYLOAD_BYTES; j++) tx_payload_out[j*8 +: 8] <= pay_r[sel_bus.index][j];
         end
      end
   end
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) free_out <= {NB{1'b1}};
      else free_out <= free_r;
   end
   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) rdata_out <= 8'h00;
      else if (rd_in) begin
         rdata_out <= 8'h00;
         if (addr_in == OFS_FREE_FLAGS) rdata_out <= 8'(free_r);
         else if (addr_in == OFS_SELECT) rdata_out <= {6'h00, sel_r};
         else if (addr_in == OFS_WINNER) rdata_out <= {busy_r, 5'h00, tx_index_out};
         else if (sel_ok) begin
            if (addr_in == OFS_ARB_UPPER) rdata_out <= upper_r[sel_r];
            else if (addr_in == OFS_ARB_LOWER) rdata_out <= lower_r[sel_r];
            else if (addr_in == OFS_ARB_X2 || addr_in == OFS_ARB_X3) rdata_out <= UNUSED_READ;
            else if (addr_in == OFS_LENGTH) rdata_out <= len_r[sel_r];
            else if (addr_in == OFS_RANK) rdata_out <= rank_r[sel_r];
            else if (addr_in >= OFS_PAYLOAD0 && addr_in < OFS_LENGTH) rdata_out <= pay_r[sel_r][pay_slot(addr_in)];
         end
      end
   end
endmodule : cmb_tx_buf
`default_nettype wire
